/* File: verilog/plt_link_tx.sv */
// Display link transmitter: pixel word capture, 16-word buffer, 7-slot serializer.
// Assumes pixel clock, pixel inputs and power-down arrive asynchronous to mclk.
//
// Operation
// R1: Capture whole 28-bit word every pixel clock; the design drops the word (word_dropped) when the buffer is full
// R2: Wide mode spreads 28 bits over four lanes
// R3: Dedicated clock lane beside data lanes
// R4: Seven bits per lane per clock period
// R5: Word holds 24 colour plus 3 timing bits
// R6: Narrow mode uses 21 bits, three lanes
// R7: Static input selects rising or falling capture
// R8: Serial format identical for both edge settings
// R9: Pixel clock stays within 20 to 85 MHz; the design samples it on the 40 MHz mclk and spends 7 mclk per word
// R10: Power-down low tristates all lane drivers
// R11: Wait 10 ms lock before valid output
// R12: Seven equally spaced slots, slot 0 first
// R13: Fixed bit-to-lane map and clock pattern
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Buffer
// ----------------------------------------
module plt_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule

// ----------------------------------------
// Transmitter
// ----------------------------------------
module plt_link_tx #(
  parameter int LOCK_CYCLES = plt_pkg::PLL_LOCK_CYCLES
) (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic                        pixel_clock_in,
  input  wire logic [plt_pkg::WORD_W-1:0]  parallel_pixel_inputs,
  input  wire logic                        edge_select_falling,
  input  wire logic                        narrow_mode,
  input  wire logic                        power_down_n,
  output plt_pkg::plt_lanes_type           lane_out,
  output plt_pkg::plt_lanes_type           lane_oe,
  output logic                             link_locked,
  output logic                             word_dropped
);

  // Fixed map: lane l, slot s carries word bit l*7+s
  function automatic logic [plt_pkg::DATA_LANES-1:0] slot_bits(
    input logic [plt_pkg::WORD_W-1:0] word,
    input logic [2:0]                 slot,
    input logic                       narrow
  );
    logic [plt_pkg::DATA_LANES-1:0] r;
    r = '0;
    for (int l = 0; l < plt_pkg::DATA_LANES; l++) begin
      r[l] = word[l * plt_pkg::SLOTS + int'(slot)]; // see R2 see R13
    end
    if (narrow) begin
      r[plt_pkg::DATA_LANES-1] = 1'b0; // see R6
    end
    return r;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic                       pclk_meta_q, pclk_sync_q, pclk_prev_q;
  logic                       pd_meta_q, pd_sync_q;
  logic [plt_pkg::WORD_W-1:0] data_meta_q, data_sync_q;
  // Static straps synced too; change them only while the link is idle
  logic                       edge_meta_q, edge_sync_q, narrow_meta_q, narrow_sync_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      pclk_meta_q <= 1'b0;
      pclk_sync_q <= 1'b0;
      pclk_prev_q <= 1'b0;
      pd_meta_q   <= 1'b0;
      pd_sync_q   <= 1'b0;
      data_meta_q <= '0;
      data_sync_q <= '0;
      edge_meta_q   <= 1'b0;
      edge_sync_q   <= 1'b0;
      narrow_meta_q <= 1'b0;
      narrow_sync_q <= 1'b0;
    end else begin
      pclk_meta_q <= pixel_clock_in;
      pclk_sync_q <= pclk_meta_q;
      pclk_prev_q <= pclk_sync_q;
      pd_meta_q   <= power_down_n;
      pd_sync_q   <= pd_meta_q;
      data_meta_q <= parallel_pixel_inputs;
      data_sync_q <= data_meta_q;
      edge_meta_q   <= edge_select_falling;
      edge_sync_q   <= edge_meta_q;
      narrow_meta_q <= narrow_mode;
      narrow_sync_q <= narrow_meta_q;
    end
  end

  // ----------------------------------------
  // Capture
  // ----------------------------------------
  // Edge choice only moves the capture moment, never the serial format
  logic pclk_rise, pclk_fall, capture;
  logic fifo_in_ready, fifo_out_valid, pop;
  logic [plt_pkg::WORD_W-1:0] fifo_out_data;
  plt_pkg::plt_state_type state_q;

  assign pclk_rise = pclk_sync_q && !pclk_prev_q;
  assign pclk_fall = !pclk_sync_q && pclk_prev_q;
  assign capture   = pd_sync_q && (edge_sync_q ? pclk_fall : pclk_rise); // see R7 see R1

  always_ff @(posedge mclk) begin
    if (srst) begin
      word_dropped <= 1'b0;
    end else begin
      word_dropped <= capture && !fifo_in_ready;
    end
  end

  // Fills while the lock wait stalls the drain
  plt_fifo #(
    .WIDTH (plt_pkg::WORD_W),
    .DEPTH (plt_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (mclk),
    .rst       (srst || !pd_sync_q),
    .in_valid  (capture),
    .in_ready  (fifo_in_ready),
    .in_data   (data_sync_q), // see R5
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------
  // Power and lock
  // ----------------------------------------
  logic [plt_pkg::LOCK_CNT_W-1:0] lock_cnt_q;
  logic                           lock_done;

  assign lock_done   = (lock_cnt_q == plt_pkg::LOCK_CNT_W'(LOCK_CYCLES - 1));
  assign link_locked = (state_q == plt_pkg::PLT_RUN);

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= plt_pkg::PLT_OFF;
    end else if (!pd_sync_q) begin
      state_q <= plt_pkg::PLT_OFF; // see R10
    end else begin
      unique case (state_q)
        plt_pkg::PLT_OFF:     state_q <= plt_pkg::PLT_LOCKING;
        plt_pkg::PLT_LOCKING: if (lock_done) state_q <= plt_pkg::PLT_RUN; // see R11
        plt_pkg::PLT_RUN:     state_q <= plt_pkg::PLT_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || state_q != plt_pkg::PLT_LOCKING) begin
      lock_cnt_q <= '0;
    end else if (!lock_done) begin
      lock_cnt_q <= lock_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Serializer
  // ----------------------------------------
  // One slot per mclk, so slots are evenly spaced at the mclk period
  logic [plt_pkg::WORD_W-1:0] word_q;
  logic [2:0]                 slot_q;
  logic                       busy_q;
  logic                       last_slot;

  assign last_slot = (slot_q == 3'(plt_pkg::LAST_SLOT));
  assign pop = link_locked && fifo_out_valid && (!busy_q || last_slot);

  always_ff @(posedge mclk) begin
    if (srst || !link_locked) begin
      busy_q <= 1'b0;
      slot_q <= plt_pkg::SLOT_RESET;
      word_q <= '0;
    end else if (pop) begin
      busy_q <= 1'b1;
      slot_q <= plt_pkg::SLOT_RESET; // see R12
      word_q <= fifo_out_data;
    end else if (busy_q && !last_slot) begin
      slot_q <= slot_q + 1'b1; // see R4
    end else begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || !link_locked) begin
      lane_out <= '0;
    end else if (pop) begin
      lane_out.data <= slot_bits(fifo_out_data, plt_pkg::SLOT_RESET, narrow_sync_q); // see R8
      lane_out.clk  <= plt_pkg::CLK_LANE_PATTERN[0]; // see R3
    end else if (busy_q && !last_slot) begin
      lane_out.data <= slot_bits(word_q, slot_q + 1'b1, narrow_sync_q);
      lane_out.clk  <= plt_pkg::CLK_LANE_PATTERN[slot_q + 1'b1]; // see R13
    end else begin
      lane_out <= '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || !pd_sync_q || !link_locked) begin
      lane_oe <= '0; // see R10
    end else begin
      lane_oe.clk  <= 1'b1;
      lane_oe.data <= {!narrow_sync_q, 3'h7}; // see R6
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_pd_tristate:   assert property (!pd_sync_q |=> lane_oe == '0) // see R10
    else $error("Lane drivers enabled in power-down");
  a_lock_wait:     assert property ($rose(link_locked) |-> $past(lock_done)) // see R11
    else $error("Run entered before lock count");
  a_capture_edge:  assert property (capture |-> (pclk_sync_q != edge_sync_q)) // see R7
    else $error("Capture on wrong clock edge");
  a_clk_pattern:   assert property (pop |=> lane_out.clk ##1 lane_out.clk // see R13
                                     ##1 !lane_out.clk ##1 !lane_out.clk ##1 !lane_out.clk)
    else $error("Clock lane pattern wrong");
  a_slot_zero:     assert property (pop |=> lane_out.data[0] == $past(fifo_out_data[0])) // see R12
    else $error("Slot 0 not first bit");
  a_seven_slots:   assert property (pop |=> busy_q [*7]) // see R4
    else $error("Word shorter than seven slots");
  a_narrow_lane:   assert property (narrow_sync_q && $past(narrow_sync_q) // see R6
                                     |-> !lane_out.data[3])
    else $error("Fourth lane used in narrow mode");
  a_capture_push:  assert property (capture && fifo_in_ready |=> !word_dropped) // see R1
    else $error("Accepted word flagged as dropped");
  a_lane_last_bit: assert property (pop |-> ##7 // see R2
                                     lane_out.data[1] == $past(fifo_out_data[13], 7))
    else $error("Lane 1 slot 6 mismatch");

  c_word_sent:  cover property (pop ##7 pop);
  c_falling:    cover property (edge_sync_q && capture);
  c_drop:       cover property (word_dropped);
  c_power_down: cover property (link_locked ##1 !pd_sync_q);

endmodule
`default_nettype wire

/* File: verilog/plt_pkg.sv */
// Constants and carrier types for the parallel-to-serial display link transmitter.
// Assumes one system clock (mclk, 40 MHz); no software-visible registers.
`default_nettype none
package plt_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int WORD_W     = 28;
  localparam int NARROW_W   = 21;
  localparam int DATA_LANES = 4;
  localparam int SLOTS      = 7;
  localparam int LAST_SLOT  = 6;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MCLK_KHZ        = 40_000;
  localparam int PLL_LOCK_MS     = 10;
  localparam int PLL_LOCK_CYCLES = PLL_LOCK_MS * MCLK_KHZ;
  localparam int LOCK_CNT_W      = 19;

  // ----------------------------------------
  // Clock lane shape, slot 0 in bit 0
  // ----------------------------------------
  localparam logic [SLOTS-1:0] CLK_LANE_PATTERN = 7'h63;
  localparam logic [2:0]       SLOT_RESET       = 3'h0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        spare;
    logic        pixel_data_valid;
    logic        frame_sync;
    logic        line_sync;
    logic [23:0] colour;
  } plt_pixel_word_type;

  typedef struct packed {
    logic [DATA_LANES-1:0] data;
    logic                  clk;
  } plt_lanes_type;

  typedef enum logic [1:0] {
    PLT_OFF,
    PLT_LOCKING,
    PLT_RUN
  } plt_state_type;

endpackage
`default_nettype wire

/* File: verif/plt_rx_model.sv */
// Link receiver model: rebuilds pixel words from the lane slots.
// Assumes one slot per mclk, idle lanes low, released lanes ignored.
`timescale 1ns/1ps
`default_nettype none
module plt_rx_model (
  input  wire plt_pkg::plt_lanes_type lane_out,
  input  wire plt_pkg::plt_lanes_type lane_oe,
  input  wire logic                   mclk,
  output logic                        rx_valid,
  output logic [27:0]                 rx_word,
  output logic                        clk_bad
);
  // ----------------------------------------
  // Deserializer
  // ----------------------------------------
  logic [27:0] acc;
  int          slot;
  initial begin
    rx_valid = 1'b0;
    rx_word = 28'h0;
    clk_bad = 1'b0;
    acc = 28'h0;
    slot = 0;
  end
  // Frame starts on clock lane high while idle; back-to-back frames rely on the slot count
  always @(posedge mclk) begin
    rx_valid <= 1'b0;
    if (slot != 0 || (lane_out.clk === 1'b1 && lane_oe.clk === 1'b1)) begin
      if (lane_out.clk !== plt_pkg::CLK_LANE_PATTERN[slot]) begin
        clk_bad <= 1'b1;
      end
      for (int l = 0; l < 4; l++) begin
        acc[l*7+slot] = lane_out.data[l] & lane_oe.data[l];
      end
      if (slot == 6) begin
        rx_word <= acc;
        rx_valid <= 1'b1;
        slot = 0;
      end else begin
        slot++;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/plt_link_tx_tb.sv */
// Testbench for the display link transmitter, self-checking against a word queue.
// Assumes the receiver model beside it; pixel clock period 8 mclk (200 ns).
`timescale 1ns/1ps
`default_nettype none
module plt_link_tx_tb;
  localparam int LOCK = 200;
  logic                   mclk, srst, pclk, edge_fall, narrow, pd_n;
  logic                   locked, dropped, rx_valid, clk_bad;
  logic [27:0]            pix, rx_word;
  plt_pkg::plt_lanes_type lane_out, lane_oe;
  int                     miscompares = 0, checks_done = 0, seed = 80, drops = 0, n;
  logic [27:0]            exp_q[$];

  plt_link_tx #(.LOCK_CYCLES(LOCK)) DUT (.mclk(mclk), .srst(srst), .pixel_clock_in(pclk),
    .parallel_pixel_inputs(pix), .edge_select_falling(edge_fall), .narrow_mode(narrow),
    .power_down_n(pd_n), .lane_out(lane_out), .lane_oe(lane_oe), .link_locked(locked),
    .word_dropped(dropped));
  plt_rx_model rx (.mclk(mclk), .lane_out(lane_out), .lane_oe(lane_oe),
    .rx_valid(rx_valid), .rx_word(rx_word), .clk_bad(clk_bad));

  // ----------------------------------------
  // Clock, checks, scoreboard
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic check(input logic [27:0] got, input logic [27:0] want);
    checks_done++;
    if (got !== want) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // An unexpected word meets an all-unknown expectation and fails
  always @(posedge mclk) begin
    if (dropped === 1'b1) drops++;
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) check(rx_word, 28'hxxxxxxx);
      else check(rx_word, exp_q.pop_front());
    end
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  // Data changes at period start, capture edge falls mid-period either way
  task automatic send(input int words, input int keep);
    logic [27:0] w;
    for (int p = 0; p < words; p++) begin
      for (int c = 0; c < 8; c++) begin
        @(negedge mclk);
        pclk = edge_fall ? (c < 4) : (c >= 4);
        if (c == 0) begin
          w = 28'($random(seed));
          pix = w;
          if (p < keep) exp_q.push_back(narrow ? {7'h00, w[20:0]} : w);
        end
      end
    end
    @(negedge mclk);
    pclk = 1'b0;
  endtask
  task automatic wait_lock(output int cyc);
    cyc = 0;
    while (locked !== 1'b1 && cyc < 1000) begin
      @(negedge mclk);
      cyc++;
    end
  endtask
  task automatic drain(input string name);
    repeat (200) @(negedge mclk);
    check(28'(exp_q.size()), 28'h0);
    $display("test %s done", name);
  endtask

  initial begin
    #(25 * 6000);
    miscompares++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    srst = 1'b1;
    pclk = 1'b0;
    edge_fall = 1'b0;
    narrow = 1'b0;
    pd_n = 1'b1;
    pix = 28'h0;
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    // Words arrive while locking: buffer takes 16, refuses 2
    send(18, 16);
    wait_lock(n);
    repeat (2) @(negedge mclk);
    check(28'(lane_oe), 28'h000001f);
    drain("fill");
    check(28'(drops), 28'h2);
    send(20, 20);
    drain("rising");
    edge_fall = 1'b1;
    send(10, 10);
    drain("falling");
    narrow = 1'b1;
    send(10, 10);
    check(28'(lane_oe), 28'h000000f);
    drain("narrow");
    narrow = 1'b0;
    pd_n = 1'b0;
    repeat (6) @(negedge mclk);
    check(28'(lane_oe), 28'h0);
    check(28'(locked), 28'h0);
    send(3, 0);
    pd_n = 1'b1;
    wait_lock(n);
    check(28'(n >= LOCK && n <= LOCK + 5), 28'h1);
    send(5, 5);
    drain("power down");
    check(28'(clk_bad), 28'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
